// [design/pcg_map.svh]
// Register offsets, field positions, reset values and timing counts of the PWM clock and channel block
`ifndef PCG_MAP_SVH
`define PCG_MAP_SVH
`define PCG_CLK_OFFS 12'h000
`define PCG_ENA_OFFS 12'h004
`define PCG_DIS_OFFS 12'h008
`define PCG_SR_OFFS 12'h00C
`define PCG_SCM_OFFS 12'h010
`define PCG_ISR_OFFS 12'h014
`define PCG_FIV_OFFS 12'h018
`define PCG_CH_BASE 12'h200
`define PCG_CH_STRIDE 12'h020
`define PCG_CMR_OFFS 12'h000
`define PCG_DUTY_VALUE_OFFS 12'h004
`define PCG_PERIOD_VALUE_OFFS 12'h00C
`define PCG_CCNT_OFFS 12'h014
`define PCG_DIVIDER_A_FACTOR_LSB 0
`define PCG_DIVIDER_A_SOURCE_SELECT_LSB 8
`define PCG_DIVIDER_B_FACTOR_LSB 16
`define PCG_DIVIDER_B_SOURCE_SELECT_LSB 24
`define PCG_CHANNEL_CLOCK_SELECT_LSB 0
`define PCG_ALIGNMENT_BIT_LSB 8
`define PCG_POLARITY_BIT_LSB 9
`define PCG_CES_LSB 10
`define PCG_CLK_RST 32'h0000_0000
`define PCG_CMR_RST 32'h0000_0000
`define PCG_CLKSEL_A 4'hB
`define PCG_CLKSEL_B 4'hC
`define PCG_PRE_TAPS 11
`endif

// [design/pcg_pkg.sv]
// Types shared by the PWM clock and channel block
package pcg_pkg;
	typedef struct packed {
		logic counter_event_select;
		logic polarity_bit;
		logic alignment_bit;
		logic [3:0] clkSel;
	} pcg_mode_type;
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} pcg_apb_req_type;
endpackage

// [design/pcg_pwm_core.sv]
// PWM clock generator with four channel counters and comparators behind an APB slave
//************************************************************
// Overview of operation
// R1 - Prescaler gives master clock divided by 1, 2, 4 ... 1024: eleven clocks.
// R2 - Two linear dividers, factor 1 to 255, give divided clocks A and B.
// R3 - Each divider counts the prescaler tap named by its source select.
// R4 - Reset clears factors and selects; a zero factor stops that divided clock.
// R5 - At reset or with clock gated, only the undivided tap is active.
// R6 - Clock stop and restart keeps all state; operation resumes where it left.
// R7 - Each channel picks one of thirteen clocks for its counter.
// R8 - Channel clock select resets to zero.
// R9 - Channel counter is 16 bits, counting up or down per mode and matches.
// R10 - Comparator uses own counter or channel 0 counter per sync member bit.
// R11 - Left aligned: count up to period value then wrap, ending the period.
// R12 - Center aligned: count up to period then down to zero, double period.
// R13 - Output is active while counter is at or beyond duty value.
// R14 - Polarity bit gives level at period start; default starts low.
// R15 - Alignment bit picks left or center; left is default.
// R16 - Output fixed 0 for duty=period, pol 0, or duty=0, pol 1.
// R17 - Output fixed 1 once enabled for duty=0, pol 0, or duty=period, pol 1.
// R18 - Polarity is taken only while the channel is disabled and acts at once.
// R19 - Left aligned channels flag an event at each period end.
// R20 - Center aligned: event at period end, also mid-period when event select is 1.
// R21 - Software enables the block clock at the power manager before use.
// R22 - Six fault inputs, 0 to 5, are accepted and readable.
// R23 - Sync members use channel 0 clock select, period and alignment.
// R24 - Clock select 0..10 are prescaler taps, 11 divided A, 12 divided B.
//************************************************************
`timescale 1ns/100ps
`default_nettype none
`include "pcg_map.svh"
module pcg_pwm_core import pcg_pkg::*; #(
	parameter int NCH = 4,
	parameter int CW = 16
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Fault inputs, external pin is bit 0
	input wire logic [5:0] faultIn,
	// Waveforms and period events
	output logic [NCH-1:0] comparatorWaveform,
	output logic [NCH-1:0] periodEvent
);
	//************************************************************
	// Register state
	//************************************************************
	logic [7:0] dividerAFactor_r, dividerBFactor_r;
	logic [3:0] dividerASourceSelect_r, dividerBSourceSelect_r;
	logic [NCH-1:0] chanEnable_r, syncMember_r, evtSticky_r;
	pcg_mode_type mode_r [NCH];
	logic [CW-1:0] dutyValue_r [NCH];
	logic [CW-1:0] periodValue_r [NCH];
	logic [CW-1:0] count_r [NCH];
	logic [NCH-1:0] down_r, wave_r, evt_r;
	logic [5:0] faultLvl_r;
	logic [10:0] pre_r;
	logic [7:0] divACnt_r, divBCnt_r;
	logic divATick_r, divBTick_r;
	logic [15:0] tick;
	logic wrEn, rdEn;
	pcg_apb_req_type req;

	assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};
	assign wrEn = req.psel && req.penable && req.pwrite && pready;
	assign rdEn = req.psel && req.penable && !req.pwrite && pready;

	// Channel index of an address in the channel window, NCH when none
	function automatic int chIdx(input logic [11:0] a, input logic [11:0] off);
		int r;
		r = NCH;
		for (int i = 0; i < NCH; i++) begin
			if (a == 12'(`PCG_CH_BASE + i * `PCG_CH_STRIDE) + off) begin
				r = i;
			end
		end
		return r;
	endfunction

	// Prescaler tap tick: undivided is every cycle, tap k when low k bits are all ones
	function automatic logic tapTick(input logic [10:0] p, input logic [3:0] k);
		logic r;
		r = 1'b1;
		for (int i = 0; i < 10; i++) begin
			if (i < int'(k) && !p[i]) begin
				r = 1'b0;
			end
		end
		if (k > 4'hA) begin
			r = 1'b0;
		end
		return r;
	endfunction

	//************************************************************
	// Clock generator
	//************************************************************
	// Free counter; only bit patterns act as enables so no derived clocks, and a gated
	// sys_clk simply freezes everything (R6); all taps but undivided are idle in reset (R5)
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			pre_r <= 11'h000; // R5
		end else begin
			pre_r <= pre_r + 11'h001; // R1
		end
	end

	// Divider A: counts ticks of its chosen tap; factor zero keeps it off
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			divACnt_r <= 8'h00;
			divATick_r <= 1'b0;
		end else if (dividerAFactor_r == 8'h00) begin
			divACnt_r <= 8'h00; // R4
			divATick_r <= 1'b0;
		end else if (tapTick(pre_r, dividerASourceSelect_r)) begin // R3
			divATick_r <= (divACnt_r + 8'h01 >= dividerAFactor_r); // R2
			divACnt_r <= (divACnt_r + 8'h01 >= dividerAFactor_r) ? 8'h00 : divACnt_r + 8'h01;
		end else begin
			divATick_r <= 1'b0;
		end
	end

	// Divider B mirrors divider A
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			divBCnt_r <= 8'h00;
			divBTick_r <= 1'b0;
		end else if (dividerBFactor_r == 8'h00) begin
			divBCnt_r <= 8'h00; // R4
			divBTick_r <= 1'b0;
		end else if (tapTick(pre_r, dividerBSourceSelect_r)) begin // R3
			divBTick_r <= (divBCnt_r + 8'h01 >= dividerBFactor_r); // R2
			divBCnt_r <= (divBCnt_r + 8'h01 >= dividerBFactor_r) ? 8'h00 : divBCnt_r + 8'h01;
		end else begin
			divBTick_r <= 1'b0;
		end
	end

	// Thirteen channel clock enables
	always_comb begin
		for (int k = 0; k < `PCG_PRE_TAPS; k++) begin
			tick[k] = tapTick(pre_r, 4'(k)); // R24
		end
		tick[`PCG_CLKSEL_A] = divATick_r; // R24
		tick[`PCG_CLKSEL_B] = divBTick_r;
		tick[15:13] = 3'b000; // Unused select codes never tick
	end

	//************************************************************
	// Register writes
	//************************************************************
	// Clock register, enable and sync set
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			dividerAFactor_r <= 8'(`PCG_CLK_RST); // R4
			dividerBFactor_r <= 8'h00;
			dividerASourceSelect_r <= 4'h0;
			dividerBSourceSelect_r <= 4'h0;
			chanEnable_r <= '0;
			syncMember_r <= '0;
		end else if (wrEn) begin
			if (req.paddr == `PCG_CLK_OFFS) begin
				dividerAFactor_r <= req.pwdata[`PCG_DIVIDER_A_FACTOR_LSB +: 8];
				dividerASourceSelect_r <= req.pwdata[`PCG_DIVIDER_A_SOURCE_SELECT_LSB +: 4];
				dividerBFactor_r <= req.pwdata[`PCG_DIVIDER_B_FACTOR_LSB +: 8];
				dividerBSourceSelect_r <= req.pwdata[`PCG_DIVIDER_B_SOURCE_SELECT_LSB +: 4];
			end
			if (req.paddr == `PCG_ENA_OFFS) begin
				chanEnable_r <= chanEnable_r | req.pwdata[NCH-1:0];
			end
			if (req.paddr == `PCG_DIS_OFFS) begin
				chanEnable_r <= chanEnable_r & ~req.pwdata[NCH-1:0];
			end
			if (req.paddr == `PCG_SCM_OFFS) begin
				// Channel 0 joins whenever any other member does
				syncMember_r <= req.pwdata[NCH-1:0] | {{(NCH-1){1'b0}}, |req.pwdata[NCH-1:0]};
			end
		end
	end

	// Per-channel mode, duty and period; polarity is frozen while enabled
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			for (int i = 0; i < NCH; i++) begin
				mode_r[i] <= pcg_mode_type'(`PCG_CMR_RST); // R8 R14 R15
				dutyValue_r[i] <= '0;
				periodValue_r[i] <= '0;
			end
		end else if (wrEn) begin
			for (int i = 0; i < NCH; i++) begin
				if (chIdx(req.paddr, `PCG_CMR_OFFS) == i) begin
					mode_r[i].clkSel <= req.pwdata[`PCG_CHANNEL_CLOCK_SELECT_LSB +: 4];
					mode_r[i].alignment_bit <= req.pwdata[`PCG_ALIGNMENT_BIT_LSB];
					mode_r[i].counter_event_select <= req.pwdata[`PCG_CES_LSB];
					if (!chanEnable_r[i]) begin
						mode_r[i].polarity_bit <= req.pwdata[`PCG_POLARITY_BIT_LSB]; // R18
					end
				end
				if (chIdx(req.paddr, `PCG_DUTY_VALUE_OFFS) == i) begin
					dutyValue_r[i] <= req.pwdata[CW-1:0];
				end
				if (chIdx(req.paddr, `PCG_PERIOD_VALUE_OFFS) == i) begin
					periodValue_r[i] <= req.pwdata[CW-1:0];
				end
			end
		end
	end

	//************************************************************
	// Channel counters and comparators
	//************************************************************
	// Counters run only when the channel, or channel 0 for a sync member, is enabled; otherwise they hold zero
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			for (int i = 0; i < NCH; i++) begin
				count_r[i] <= '0;
			end
			down_r <= '0;
			evt_r <= '0;
		end else begin
			for (int i = 0; i < NCH; i++) begin
				automatic int s = syncMember_r[i] ? 0 : i; // R23
				automatic logic [CW-1:0] per = periodValue_r[s];
				automatic logic ctr = mode_r[s].alignment_bit;
				evt_r[i] <= 1'b0;
				if (!chanEnable_r[s]) begin
					count_r[i] <= '0;
					down_r[i] <= 1'b0;
				end else if (tick[mode_r[s].clkSel]) begin // R7
					if (!ctr) begin
						down_r[i] <= 1'b0;
						if (count_r[i] + 1'b1 >= per) begin
							count_r[i] <= '0; // R11
							evt_r[i] <= 1'b1; // R19
						end else begin
							count_r[i] <= count_r[i] + 1'b1; // R9
						end
					end else if (!down_r[i]) begin
						if (count_r[i] + 1'b1 >= per) begin
							down_r[i] <= 1'b1; // R12
							evt_r[i] <= mode_r[i].counter_event_select; // R20
						end
						count_r[i] <= count_r[i] + 1'b1;
					end else if (count_r[i] <= 1) begin
						count_r[i] <= '0;
						down_r[i] <= 1'b0;
						evt_r[i] <= 1'b1; // R12 R20
					end else begin
						count_r[i] <= count_r[i] - 1'b1; // R9
					end
				end
			end
		end
	end

	// Waveform: start level is polarity, the other level from duty onward
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			wave_r <= '0;
		end else begin
			for (int i = 0; i < NCH; i++) begin
				automatic int c = syncMember_r[i] ? 0 : i; // R10
				automatic logic [CW-1:0] per = periodValue_r[c];
				automatic logic act = count_r[c] >= dutyValue_r[i];
				if (!chanEnable_r[i]) begin
					wave_r[i] <= mode_r[i].polarity_bit; // R18
				end else if (dutyValue_r[i] >= per) begin
					wave_r[i] <= mode_r[i].polarity_bit; // R16 R17
				end else if (dutyValue_r[i] == 0) begin
					wave_r[i] <= ~mode_r[i].polarity_bit; // R16 R17
				end else begin
					wave_r[i] <= act ? ~mode_r[i].polarity_bit : mode_r[i].polarity_bit; // R13 R14
				end
			end
		end
	end

	//************************************************************
	// Status, faults and read back
	//************************************************************
	// Sticky events; read of the status clears, a new event in the same cycle wins
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			evtSticky_r <= '0;
			faultLvl_r <= 6'h00;
			periodEvent <= '0;
			comparatorWaveform <= '0;
		end else begin
			faultLvl_r <= faultIn; // R22
			periodEvent <= evt_r;
			comparatorWaveform <= wave_r;
			if (rdEn && req.paddr == `PCG_ISR_OFFS) begin
				evtSticky_r <= evt_r;
			end else begin
				evtSticky_r <= evtSticky_r | evt_r;
			end
		end
	end

	// Single wait-free APB: ready low in reset and high from then on, unmapped reads zero with error
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= 1'b1;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
			if (req.psel && !req.penable) begin
				unique case (req.paddr)
					`PCG_CLK_OFFS: prdata <= {4'h0, dividerBSourceSelect_r, dividerBFactor_r,
						4'h0, dividerASourceSelect_r, dividerAFactor_r};
					`PCG_SR_OFFS: prdata <= 32'(chanEnable_r);
					`PCG_SCM_OFFS: prdata <= 32'(syncMember_r);
					`PCG_ISR_OFFS: prdata <= 32'(evtSticky_r | evt_r);
					`PCG_FIV_OFFS: prdata <= 32'(faultLvl_r);
					`PCG_ENA_OFFS, `PCG_DIS_OFFS: prdata <= 32'h0000_0000;
					default: begin
						if (chIdx(req.paddr, `PCG_CMR_OFFS) < NCH) begin
							prdata <= 32'(mode_r[chIdx(req.paddr, `PCG_CMR_OFFS)].clkSel)
								| {21'h0, mode_r[chIdx(req.paddr, `PCG_CMR_OFFS)].counter_event_select,
								mode_r[chIdx(req.paddr, `PCG_CMR_OFFS)].polarity_bit,
								mode_r[chIdx(req.paddr, `PCG_CMR_OFFS)].alignment_bit, 8'h00};
						end else if (chIdx(req.paddr, `PCG_DUTY_VALUE_OFFS) < NCH) begin
							prdata <= 32'(dutyValue_r[chIdx(req.paddr, `PCG_DUTY_VALUE_OFFS)]);
						end else if (chIdx(req.paddr, `PCG_PERIOD_VALUE_OFFS) < NCH) begin
							prdata <= 32'(periodValue_r[chIdx(req.paddr, `PCG_PERIOD_VALUE_OFFS)]);
						end else if (chIdx(req.paddr, `PCG_CCNT_OFFS) < NCH) begin
							prdata <= 32'(count_r[chIdx(req.paddr, `PCG_CCNT_OFFS)]);
						end else begin
							pslverr <= !req.pwrite; // Unmapped writes stay silent
						end
					end
				endcase
			end
		end
	end

	//************************************************************
	// Assertions
	//************************************************************
	a_divider_off: assert property (@(posedge sys_clk) disable iff (!rstn)
		dividerAFactor_r == 8'h00 |=> !divATick_r) // R4
		else $error("divided clock A ticks with zero factor");
	a_left_wrap: assert property (@(posedge sys_clk) disable iff (!rstn)
		chanEnable_r[0] && !syncMember_r[0] && !mode_r[0].alignment_bit && tick[mode_r[0].clkSel]
		&& count_r[0] + 1'b1 >= periodValue_r[0] |=> count_r[0] == 0 && evt_r[0]) // R11 R19
		else $error("left aligned counter did not wrap with event");
	a_pol_frozen: assert property (@(posedge sys_clk) disable iff (!rstn)
		chanEnable_r[2] && $past(chanEnable_r[2]) |-> $stable(mode_r[2].polarity_bit)) // R18
		else $error("polarity changed while enabled");
	a_fixed_low: assert property (@(posedge sys_clk) disable iff (!rstn)
		chanEnable_r[2] && dutyValue_r[2] >= periodValue_r[syncMember_r[2] ? 0 : 2]
		&& !mode_r[2].polarity_bit |=> !wave_r[2]) // R16
		else $error("waveform not fixed low");
	a_fixed_high: assert property (@(posedge sys_clk) disable iff (!rstn)
		chanEnable_r[2] && dutyValue_r[2] == 0 && !mode_r[2].polarity_bit |=> wave_r[2]) // R17
		else $error("waveform not fixed high");
	a_count_bound: assert property (@(posedge sys_clk) disable iff (!rstn)
		!chanEnable_r[3] |=> count_r[3] == 0) // R9
		else $error("disabled counter not held at zero");
	a_reset_clean: assert property (@(posedge sys_clk)
		!rstn |=> pre_r == 0 && !divATick_r && !divBTick_r) // R5
		else $error("prescaler taps active after reset");
	a_event_out: assert property (@(posedge sys_clk) disable iff (!rstn)
		evt_r[0] |=> periodEvent[0] && evtSticky_r[0]) // R20
		else $error("period event not reported");
endmodule // pcg_pwm_core
`default_nettype wire

// [verification/pcg_switch_model.sv]
// Behavioural model of the power switch bank driven by the channel waveforms
`timescale 1ns/100ps
`default_nettype none
module pcg_switch_model #(
	parameter int NCH = 4
) (
	// Clock
	input wire logic sys_clk,
	// Measurement control from the bench
	input wire logic clr,
	input wire logic measure,
	// Gate drive from the channels
	input wire logic [NCH-1:0] gateDrive,
	// Integrated on-time of each switch, in master clock cycles
	output logic [NCH-1:0][31:0] onCycles
);
	// A switch sees only its gate level, so a stuck level and a long pulse look alike;
	// the bench therefore measures over whole numbers of periods
	always_ff @(posedge sys_clk) begin
		for (int i = 0; i < NCH; i++) begin
			if (clr) begin
				onCycles[i] <= 32'h0000_0000;
			end else if (measure && gateDrive[i]) begin
				onCycles[i] <= onCycles[i] + 32'h0000_0001;
			end
		end
	end
endmodule // pcg_switch_model
`default_nettype wire

// [verification/tb_pwm_clock_gen_and_channel_comparator.sv]
// Self-checking testbench of the PWM clock generator and channel comparators
`timescale 1ns/100ps
`default_nettype none
`include "pcg_map.svh"
module tb_pwm_clock_gen_and_channel_comparator import pcg_pkg::*;;
	//************************************************************
	// Signals, design and switch model
	//************************************************************
	typedef struct {int ch, sel, alignment_bit, polarity_bit, counter_event_select, per, dty, expHigh, tol, expEv;} pcg_row_type;
	logic sys_clk, rstn, psel, penable, pwrite, pready, pslverr, clr, measure;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [5:0] faultIn;
	logic [3:0] comparatorWaveform, periodEvent;
	logic [3:0][31:0] onCycles;
	logic [31:0] evCount [4];
	int n_mismatch, total_checks;
	// Center rows allow one tick per period of slack at the turn-around
	pcg_row_type rows [9] = '{
		'{0, 0, 0, 0, 0, 8, 3, 20, 0, 4}, '{1, 1, 0, 1, 0, 6, 2, 16, 0, 4},
		'{2, 11, 0, 0, 0, 5, 0, 120, 0, 4}, '{3, 12, 0, 1, 0, 4, 4, 64, 0, 4},
		'{0, 2, 1, 0, 0, 6, 2, 128, 16, 4}, '{1, 0, 1, 0, 1, 5, 3, 16, 4, 8},
		'{2, 0, 0, 0, 0, 7, 7, 0, 0, 4}, '{3, 0, 0, 1, 0, 7, 0, 0, 0, 4},
		'{0, 10, 0, 0, 0, 2, 1, 4096, 0, 4}};
	pcg_pwm_core #(.NCH(4), .CW(16)) i_pcg_pwm_core (.sys_clk(sys_clk), .rstn(rstn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .faultIn(faultIn),
		.comparatorWaveform(comparatorWaveform), .periodEvent(periodEvent));
	pcg_switch_model #(.NCH(4)) i_pcg_switch_model (.sys_clk(sys_clk), .clr(clr),
		.measure(measure), .gateDrive(comparatorWaveform), .onCycles(onCycles));
	// Clock and the bench's own event counter
	initial sys_clk = 1'b0;
	always #4 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		for (int i = 0; i < 4; i++) begin
			if (clr) begin
				evCount[i] <= 32'h0000_0000;
			end else if (measure && periodEvent[i]) begin
				evCount[i] <= evCount[i] + 32'h0000_0001;
			end
		end
	end
	//************************************************************
	// Tasks
	//************************************************************
	task automatic mismatch(input string msg);
		$display("MISMATCH at %0t: %s", $time, msg);
		n_mismatch++;
	endtask
	task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			mismatch($sformatf("%s got %h expected %h", what, got, exp));
		end
	endtask
	task automatic check_near(input logic [31:0] got, input int exp, input int tol);
		total_checks++;
		if ($isunknown(got) || int'(got) > exp + tol || int'(got) < exp - tol) begin
			mismatch($sformatf("on-time got %0d expected %0d", got, exp));
		end
	endtask
	// One APB transfer; the request stands until pready is sampled high
	task automatic apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
			output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) begin
			mismatch("no pready");
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb_xfer(1'b1, a, d, r, e);
	endtask
	task automatic rd_check(input logic [11:0] a, input logic [31:0] exp, input logic expErr);
		logic [31:0] r;
		logic e;
		apb_xfer(1'b0, a, 32'h0000_0000, r, e);
		check_val(r, exp, "read data");
		check_val({31'h0000_0000, e}, {31'h0000_0000, expErr}, "slave error");
	endtask
	function automatic logic [11:0] ch_addr(input int ch, input logic [11:0] off);
		return `PCG_CH_BASE + 12'(ch) * `PCG_CH_STRIDE + off;
	endfunction
	// Cycles per channel tick: taps double, A is tap 1 times 3, B is tap 2 times 1
	function automatic int tick(input int sel);
		return (sel < 11) ? (1 << sel) : ((sel == 11) ? 6 : 4);
	endfunction
	task automatic measure_window(input int w);
		@(posedge sys_clk);
		clr <= 1'b1;
		@(posedge sys_clk);
		clr <= 1'b0;
		measure <= 1'b1;
		repeat (w) @(posedge sys_clk);
		measure <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic do_reset();
		@(posedge sys_clk);
		rstn <= 1'b0;
		repeat (5) @(posedge sys_clk);
		check_val(32'({comparatorWaveform, periodEvent, pready}), 32'h0000_0000, "in reset");
		rstn <= 1'b1;
	endtask
	task automatic tally_and_finish();
		$display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	//************************************************************
	// Tests
	//************************************************************
	initial begin
		#400000;
		mismatch("watchdog expired");
		tally_and_finish();
	end
	initial begin
		pcg_row_type r;
		int w;
		{rstn, psel, penable, pwrite, clr, measure} = 6'h00;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		faultIn = 6'h00;
		do_reset();
		// Table rows: one channel each, whole periods measured after one settling period
		foreach (rows[k]) begin
			r = rows[k];
			wr(`PCG_DIS_OFFS, 32'h0000_000F);
			wr(`PCG_CLK_OFFS, 32'h0201_0103);
			wr(ch_addr(r.ch, `PCG_CMR_OFFS), 32'(r.sel) | 32'(r.alignment_bit) << `PCG_ALIGNMENT_BIT_LSB
				| 32'(r.polarity_bit) << `PCG_POLARITY_BIT_LSB | 32'(r.counter_event_select) << `PCG_CES_LSB);
			wr(ch_addr(r.ch, `PCG_DUTY_VALUE_OFFS), 32'(r.dty));
			wr(ch_addr(r.ch, `PCG_PERIOD_VALUE_OFFS), 32'(r.per));
			wr(`PCG_ENA_OFFS, 32'h0000_0001 << r.ch);
			w = 4 * tick(r.sel) * r.per * (r.alignment_bit + 1);
			repeat (w / 4 + 4) @(posedge sys_clk);
			measure_window(w);
			check_near(onCycles[r.ch], r.expHigh, r.tol);
			check_val(evCount[r.ch], 32'(r.expEv), "events");
		end
		// Channel 1 follows channel 0's counter, clock, period and alignment
		wr(`PCG_DIS_OFFS, 32'h0000_000F);
		wr(ch_addr(0, `PCG_CMR_OFFS), 32'h0000_0000);
		wr(ch_addr(0, `PCG_DUTY_VALUE_OFFS), 32'h0000_0002);
		wr(ch_addr(0, `PCG_PERIOD_VALUE_OFFS), 32'h0000_0004);
		wr(ch_addr(1, `PCG_CMR_OFFS), 32'h0000_0102);
		wr(ch_addr(1, `PCG_PERIOD_VALUE_OFFS), 32'h0000_0008);
		wr(ch_addr(1, `PCG_DUTY_VALUE_OFFS), 32'h0000_0002);
		wr(`PCG_SCM_OFFS, 32'h0000_0002);
		wr(`PCG_ENA_OFFS, 32'h0000_0003);
		repeat (20) @(posedge sys_clk);
		measure_window(16);
		check_val(evCount[1], 32'h0000_0004, "sync events");
		check_val(onCycles[1], 32'h0000_0008, "sync on-time");
		wr(`PCG_SCM_OFFS, 32'h0000_0000);
		// Polarity acts at once while disabled and is ignored while enabled
		wr(`PCG_DIS_OFFS, 32'h0000_000F);
		wr(ch_addr(2, `PCG_DUTY_VALUE_OFFS), 32'h0000_0000);
		wr(ch_addr(2, `PCG_PERIOD_VALUE_OFFS), 32'h0000_0005);
		wr(ch_addr(2, `PCG_CMR_OFFS), 32'h0000_0200);
		repeat (3) @(posedge sys_clk);
		check_val(32'(comparatorWaveform[2]), 32'h0000_0001, "polarity high");
		wr(ch_addr(2, `PCG_CMR_OFFS), 32'h0000_0000);
		repeat (3) @(posedge sys_clk);
		check_val(32'(comparatorWaveform[2]), 32'h0000_0000, "polarity low");
		wr(`PCG_ENA_OFFS, 32'h0000_0004);
		repeat (12) @(posedge sys_clk);
		check_val(32'(comparatorWaveform[2]), 32'h0000_0001, "fixed high");
		wr(ch_addr(2, `PCG_CMR_OFFS), 32'h0000_0200);
		repeat (12) @(posedge sys_clk);
		check_val(32'(comparatorWaveform[2]), 32'h0000_0001, "kept high");
		wr(`PCG_DIS_OFFS, 32'h0000_0004);
		repeat (3) @(posedge sys_clk);
		check_val(32'(comparatorWaveform[2]), 32'h0000_0000, "old polarity");
		// Fault levels, unmapped read, then a reset in mid-run
		faultIn <= 6'h2D;
		rd_check(`PCG_FIV_OFFS, 32'h0000_002D, 1'b0);
		rd_check(12'h100, 32'h0000_0000, 1'b1);
		wr(ch_addr(0, `PCG_CMR_OFFS), 32'h0000_0705);
		do_reset();
		rd_check(`PCG_CLK_OFFS, `PCG_CLK_RST, 1'b0);
		rd_check(ch_addr(0, `PCG_CMR_OFFS), `PCG_CMR_RST, 1'b0);
		tally_and_finish();
	end
endmodule // tb_pwm_clock_gen_and_channel_comparator
`default_nettype wire
